// [verilog/pac_pkg.sv]
// constants, register numbers and mode codes for the panel, alarm and configuration controller
package pac_pkg;

    // system clock rate and derived cycles per millisecond
    localparam int CLK_HZ = 250_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int MS_CNT_W = 18;

    // key timing and restart hold-off, in milliseconds
    localparam logic [7:0] REPEAT_MS = 8'hFA;
    localparam logic [11:0] HOLD_MS = 12'hFA0;
    localparam logic [4:0] RESTART_MS = 5'h14;

    // value width and register numbers as shown on the display
    localparam int VAL_W = 10;
    localparam logic [9:0] REG_FW = 10'h065;
    localparam logic [9:0] REG_GRAPH = 10'h066;
    localparam logic [9:0] REG_LATCH = 10'h067;
    localparam logic [9:0] REG_EXTAMP = 10'h068;
    localparam logic [9:0] REG_FIRST = REG_FW;
    localparam logic [9:0] REG_LAST = REG_EXTAMP;

    // limits and defaults
    localparam logic [9:0] AMP_DEF = 10'h064;
    localparam logic [9:0] AMP_MIN = 10'h00A;
    localparam logic [9:0] AMP_MAX = 10'h064;
    localparam logic [9:0] BIT_MIN = 10'h000;
    localparam logic [9:0] BIT_MAX = 10'h001;
    localparam logic [9:0] STEP_SMALL = 10'h001;
    localparam logic [9:0] STEP_BIG = 10'h005;
    localparam logic GRAPH_DEF = 1'b0;
    localparam logic LATCH_DEF = 1'b0;
    localparam logic EXTAMP_DEF = 1'b0;

    // bit positions of the synchronised pin vector
    localparam int PIN_N = 7;
    localparam int PIN_START = 0;
    localparam int PIN_CLR = 1;
    localparam int PIN_OVL = 2;
    localparam int PIN_MENU = 3;
    localparam int PIN_UP = 4;
    localparam int PIN_DOWN = 5;
    localparam int PIN_RESET = 6;

    // front-panel display modes
    typedef enum logic [1:0]
    {
        MODE_AMP = 2'b00,
        MODE_REG = 2'b01,
        MODE_VAL = 2'b10
    } pac_mode_e;

endpackage : pac_pkg

// [verilog/pac_key_rpt.sv]
// press, auto-repeat and long-hold detection for one arrow key
`timescale 1ns/1ns
module pac_key_rpt
    import pac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic key_lvl,
    input wire logic ms_tick,
    output logic step,
    output logic step_big
);

    logic key_prev_r;
    logic [7:0] rep_cnt_r;
    logic [11:0] hold_cnt_r;
    logic rep_due;

    assign rep_due = key_lvl && key_prev_r && ms_tick && (rep_cnt_r == REPEAT_MS - 8'h01);

    // step at the press and then at each repeat interval
    assign step = (key_lvl && !key_prev_r) || rep_due;
    assign step_big = (hold_cnt_r == HOLD_MS);

    // press edge detection
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            key_prev_r <= 1'b0;
        else
            key_prev_r <= key_lvl;
    end

    // repeat interval counter, restarted on release
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !key_lvl || !key_prev_r)
            rep_cnt_r <= 8'h00;
        else if (rep_due)
            rep_cnt_r <= 8'h00;
        else if (ms_tick)
            rep_cnt_r <= rep_cnt_r + 8'h01;
    end

    // hold time counter, saturates at the long-hold mark
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !key_lvl)
            hold_cnt_r <= 12'h000;
        else if (ms_tick && (hold_cnt_r != HOLD_MS))
            hold_cnt_r <= hold_cnt_r + 12'h001;
    end

    // repeat counter never passes the interval
    rep_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rep_cnt_r < REPEAT_MS)
        else $error("repeat counter past interval");

    // release clears the hold time
    hold_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !key_lvl |=> (hold_cnt_r == 12'h000) && !step_big)
        else $error("hold time kept after release");

endmodule : pac_key_rpt

// [verilog/pac_ctrl.sv]
// front-panel amplitude, alarm and register menu controller
//
// Behaviour
// - ultrasonic output turns on when the external start input becomes active.
// - output stays on while start is active; off when start drops.
// - after reset the display shows the stored amplitude with percent icon.
// - in amplitude mode each arrow press changes amplitude by one percent.
// - holding an arrow in amplitude mode repeats one percent every 250 ms.
// - after four seconds held the amplitude repeat step becomes five percent.
// - external amplitude control locks amplitude keys and shows three dashes.
// - overload lights the alarm icon and drives the general alarm output.
// - latching alarm holds until panel reset key or external clear input.
// - non-latching alarm clears when start is removed and re-applied.
// - after an alarm clears, output stays off at least 20 ms.
// - register mode shows register 101 first, later the last selected one.
// - arrows step register numbers; menu key shows that value, circle icon.
// - value editing steps by one per press and repeats every 250 ms.
// - after four seconds held the value repeat step becomes five.
// - reset key while editing loads the register default into the buffer.
// - menu key while editing commits the value and returns to amplitude.
// - a one-bit register picks post-weld bar graph: 0 power, 1 frequency.
// - a one-bit register selects latching alarms when 1, default 0.
// - a one-bit register enables external amplitude control when 1, default 0.
`timescale 1ns/1ns
module pac_ctrl
    import pac_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES,
    parameter logic [9:0] FW_VERSION = 10'h07B // arbitrary value
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ext_start,
    input wire logic ext_alarm_clear,
    input wire logic overload,
    input wire logic key_menu,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_reset,
    output logic us_enable,
    output logic general_alarm,
    output logic alarm_icon,
    output logic pct_icon,
    output logic num_icon,
    output logic circle_icon,
    output logic disp_dashes,
    output logic [9:0] disp_value,
    output logic graph_freq_sel,
    output logic ext_amp_enable
);

    logic [PIN_N-1:0] pin_meta_r;
    logic [PIN_N-1:0] pin_sync_r;
    logic [PIN_N-1:0] pin_prev_r;
    logic start_s;
    logic clr_s;
    logic ovl_s;
    logic menu_press;
    logic reset_press;
    logic start_rise;
    logic [MS_CNT_W-1:0] ms_cnt_r;
    logic ms_tick;
    logic up_step;
    logic up_big;
    logic dn_step;
    logic dn_big;
    logic step_any;
    logic step_up;
    logic step_big;
    pac_mode_e mode_r;
    logic [9:0] amp_r;
    logic [9:0] sel_r;
    logic [9:0] edit_r;
    logic graph_r;
    logic latch_r;
    logic extamp_r;
    logic alarm_r;
    logic alarm_clear;
    logic hold_act_r;
    logic [4:0] hold_cnt_r;
    logic us_on_r;
    logic [9:0] sel_val;
    logic [9:0] sel_lo;
    logic [9:0] sel_hi;
    logic [9:0] sel_def;
    logic sel_rw;
    logic [9:0] disp_r;
    logic dash_r;

    // step a value by one or five, clamped to its limits
    function automatic logic [9:0] clamp_step(input logic [9:0] v, input logic up, input logic big,
                                              input logic [9:0] lo, input logic [9:0] hi);
        logic [10:0] d;
        logic [10:0] s;
        d = big ? {1'b0, STEP_BIG} : {1'b0, STEP_SMALL};
        s = 11'h000;
        if (up)
        begin
            s = {1'b0, v} + d;
            clamp_step = (s > {1'b0, hi}) ? hi : s[9:0];
        end
        else
        begin
            s = {1'b0, lo} + d;
            clamp_step = ({1'b0, v} < s) ? lo : v - d[9:0];
        end
    endfunction : clamp_step

    // two-flop synchronisers for every pin input
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            pin_prev_r <= '0;
        end
        else
        begin
            pin_meta_r <= {key_reset, key_down, key_up, key_menu, overload, ext_alarm_clear, ext_start};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // synchronised levels and press edges
    assign start_s = pin_sync_r[PIN_START];
    assign clr_s = pin_sync_r[PIN_CLR];
    assign ovl_s = pin_sync_r[PIN_OVL];
    assign menu_press = pin_sync_r[PIN_MENU] && !pin_prev_r[PIN_MENU];
    assign reset_press = pin_sync_r[PIN_RESET] && !pin_prev_r[PIN_RESET];
    assign start_rise = start_s && !pin_prev_r[PIN_START];

    // millisecond enable divider
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || ms_tick)
            ms_cnt_r <= '0;
        else
            ms_cnt_r <= ms_cnt_r + 18'h00001;
    end
    assign ms_tick = (ms_cnt_r == MS_CNT_W'(MS_CYC - 1));

    // one repeat engine per arrow key
    pac_key_rpt u_rpt_up
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .key_lvl(pin_sync_r[PIN_UP]),
        .ms_tick(ms_tick),
        .step(up_step),
        .step_big(up_big)
    );

    pac_key_rpt u_rpt_dn
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .key_lvl(pin_sync_r[PIN_DOWN]),
        .ms_tick(ms_tick),
        .step(dn_step),
        .step_big(dn_big)
    );

    // up wins when both arrows step together
    assign step_any = up_step || dn_step;
    assign step_up = up_step;
    assign step_big = up_step ? up_big : dn_big;

    // limits, default and current value of the selected register
    always_comb
    begin
        sel_val = {9'h000, graph_r};
        sel_lo = BIT_MIN;
        sel_hi = BIT_MAX;
        sel_def = BIT_MIN;
        sel_rw = 1'b1;
        unique case (sel_r)
            REG_FW:
            begin
                sel_val = FW_VERSION;
                sel_lo = FW_VERSION;
                sel_hi = FW_VERSION;
                sel_def = FW_VERSION;
                sel_rw = 1'b0;
            end
            REG_GRAPH: sel_val = {9'h000, graph_r};
            REG_LATCH: sel_val = {9'h000, latch_r};
            REG_EXTAMP: sel_val = {9'h000, extamp_r};
            default: sel_val = {9'h000, graph_r};
        endcase
    end

    // menu mode sequencing
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            mode_r <= MODE_AMP;
        else if (menu_press)
        begin
            unique case (mode_r)
                MODE_AMP: mode_r <= MODE_REG;
                MODE_REG: mode_r <= MODE_VAL;
                MODE_VAL: mode_r <= MODE_AMP;
                default: mode_r <= MODE_AMP;
            endcase
        end
    end

    // amplitude setting from the arrow keys
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            amp_r <= AMP_DEF;
        else if ((mode_r == MODE_AMP) && !extamp_r && step_any && !menu_press)
            amp_r <= clamp_step(amp_r, step_up, step_big, AMP_MIN, AMP_MAX);
    end

    // register selection, kept across visits
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sel_r <= REG_FIRST;
        else if ((mode_r == MODE_REG) && step_any && !menu_press)
            sel_r <= clamp_step(sel_r, step_up, 1'b0, REG_FIRST, REG_LAST);
    end

    // edit buffer: load, step and default
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            edit_r <= BIT_MIN;
        else if ((mode_r == MODE_REG) && menu_press)
            edit_r <= sel_val;
        else if ((mode_r == MODE_VAL) && reset_press)
            edit_r <= sel_def;
        else if ((mode_r == MODE_VAL) && step_any && !menu_press)
            edit_r <= clamp_step(edit_r, step_up, step_big, sel_lo, sel_hi);
    end

    // configuration bits, written on commit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            graph_r <= GRAPH_DEF;
            latch_r <= LATCH_DEF;
            extamp_r <= EXTAMP_DEF;
        end
        else if ((mode_r == MODE_VAL) && menu_press && sel_rw)
        begin
            if (sel_r == REG_GRAPH)
                graph_r <= edit_r[0];
            if (sel_r == REG_LATCH)
                latch_r <= edit_r[0];
            if (sel_r == REG_EXTAMP)
                extamp_r <= edit_r[0];
        end
    end

    // alarm clear source depends on latching mode
    assign alarm_clear = latch_r ? (reset_press || clr_s) : start_rise;

    // overload alarm, set wins over clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            alarm_r <= 1'b0;
        else if (ovl_s)
            alarm_r <= 1'b1;
        else if (alarm_clear)
            alarm_r <= 1'b0;
    end

    // restart hold-off after an alarm clears
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hold_act_r <= 1'b0;
            hold_cnt_r <= 5'h00;
        end
        else if (alarm_r && !ovl_s && alarm_clear)
        begin
            hold_act_r <= 1'b1;
            hold_cnt_r <= 5'h00;
        end
        else if (hold_act_r && ms_tick)
        begin
            if (hold_cnt_r == RESTART_MS)
                hold_act_r <= 1'b0;
            else
                hold_cnt_r <= hold_cnt_r + 5'h01;
        end
    end

    // ultrasonic gate follows the start level
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            us_on_r <= 1'b0;
        else
            us_on_r <= start_s && !alarm_r && !hold_act_r && !ovl_s;
    end

    // display value register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            disp_r <= AMP_DEF;
            dash_r <= 1'b0;
        end
        else
        begin
            unique case (mode_r)
                MODE_AMP: disp_r <= amp_r;
                MODE_REG: disp_r <= sel_r;
                MODE_VAL: disp_r <= edit_r;
                default: disp_r <= amp_r;
            endcase
            dash_r <= (mode_r == MODE_AMP) && extamp_r;
        end
    end

    // outputs
    assign us_enable = us_on_r;
    assign general_alarm = alarm_r;
    assign alarm_icon = alarm_r;
    assign pct_icon = (mode_r == MODE_AMP);
    assign num_icon = (mode_r == MODE_REG);
    assign circle_icon = (mode_r == MODE_VAL);
    assign disp_dashes = dash_r;
    assign disp_value = disp_r;
    assign graph_freq_sel = graph_r;
    assign ext_amp_enable = extamp_r;

    // output follows start when nothing blocks it
    us_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_s && !alarm_r && !hold_act_r && !ovl_s |=> us_enable)
        else $error("output not started");

    // start drop turns output off next edge
    us_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !start_s |=> !us_enable)
        else $error("output on without start");

    // amplitude shown with percent icon after reset
    reset_disp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> pct_icon && (disp_value == AMP_DEF) && (amp_r == AMP_DEF))
        else $error("reset display wrong");

    // single press steps amplitude by one
    amp_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode_r == MODE_AMP) && !extamp_r && up_step && !up_big && !menu_press && (amp_r < AMP_MAX)
        |=> amp_r == $past(amp_r) + STEP_SMALL)
        else $error("amplitude step not one");

    // long hold steps amplitude by five down
    amp_big_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode_r == MODE_AMP) && !extamp_r && dn_step && !up_step && dn_big && !menu_press
        && (amp_r >= AMP_MIN + STEP_BIG) |=> amp_r == $past(amp_r) - STEP_BIG)
        else $error("amplitude long step not five");

    // external control freezes amplitude and shows dashes
    ext_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        extamp_r && (mode_r == MODE_AMP) |=> $stable(amp_r) && disp_dashes)
        else $error("amplitude not locked");

    // overload raises both alarm outputs
    alarm_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovl_s |=> general_alarm && alarm_icon && !us_enable)
        else $error("alarm not raised");

    // latched alarm waits for a clear
    latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_r && latch_r && !reset_press && !clr_s |=> alarm_r)
        else $error("latched alarm dropped");

    // non-latching alarm ignores the reset key
    nolatch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_r && !latch_r && !start_rise |=> alarm_r)
        else $error("non-latching alarm dropped");

    // no restart right after an alarm clears
    restart_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(alarm_r) |-> !us_enable [*8])
        else $error("restart inside hold-off");

    // commit returns to amplitude display
    menu_commit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode_r == MODE_VAL) && menu_press |=> pct_icon ##1 (disp_value == amp_r))
        else $error("commit did not return");

    // amplitude always inside its limits
    amp_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (amp_r >= AMP_MIN) && (amp_r <= AMP_MAX) && (sel_r >= REG_FIRST) && (sel_r <= REG_LAST))
        else $error("value outside limits");

endmodule : pac_ctrl

// [tb/pac_mach_model.sv]
// machine controller model driving start, alarm clear and overload pins
`timescale 1ns/1ns
module pac_mach_model
#(
    parameter int MS_CYC = 10
)
(
    input wire logic sys_clk,
    output logic ext_start,
    output logic ext_alarm_clear,
    output logic overload
);
    // all pins idle low from time zero
    initial
    begin
        ext_start = 1'b0;
        ext_alarm_clear = 1'b0;
        overload = 1'b0;
    end

    // level change on the start line, off the sampling edge
    task set_start(input logic v);
        @(negedge sys_clk);
        ext_start = v;
    endtask : set_start

    // remove and re-apply start, never sooner than one ms apart
    task restart();
        set_start(1'b0);
        repeat (MS_CYC) @(negedge sys_clk);
        set_start(1'b1);
    endtask : restart

    // short overload event, long enough to pass the synchroniser
    task pulse_overload();
        @(negedge sys_clk);
        overload = 1'b1;
        repeat (4) @(negedge sys_clk);
        overload = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : pulse_overload

    // external alarm clear, raised only after overload has gone
    task pulse_clear();
        @(negedge sys_clk);
        ext_alarm_clear = 1'b1;
        repeat (4) @(negedge sys_clk);
        ext_alarm_clear = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : pulse_clear
endmodule : pac_mach_model

// [tb/tb_pac_ctrl.sv]
// self-checking testbench for the panel, alarm and configuration controller
`timescale 1ns/1ns
module tb_pac_ctrl;
    import pac_pkg::*;
    localparam int MSC = 10;
    localparam logic [9:0] ON = 10'h001;
    localparam logic [9:0] OFF = 10'h000;
    localparam logic [3:0] K_MENU = 4'h1;
    localparam logic [3:0] K_UP = 4'h2;
    localparam logic [3:0] K_DN = 4'h4;
    localparam logic [3:0] K_RST = 4'h8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] keys = 4'h0;
    logic key_menu;
    logic key_up;
    logic key_down;
    logic key_reset;
    logic ext_start;
    logic ext_alarm_clear;
    logic overload;
    logic us_enable;
    logic general_alarm;
    logic alarm_icon;
    logic pct_icon;
    logic num_icon;
    logic circle_icon;
    logic disp_dashes;
    logic [9:0] disp_value;
    logic graph_freq_sel;
    logic ext_amp_enable;
    logic [9:0] amp_exp;
    logic [9:0] v;
    int num_errors = 0;
    int comparisons = 0;

    // free-running system clock
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    // key vector split into the four panel key lines
    assign key_menu = keys[0];
    assign key_up = keys[1];
    assign key_down = keys[2];
    assign key_reset = keys[3];

    pac_ctrl #(.MS_CYC(MSC)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ext_start(ext_start),
        .ext_alarm_clear(ext_alarm_clear), .overload(overload), .key_menu(key_menu), .key_up(key_up),
        .key_down(key_down), .key_reset(key_reset), .us_enable(us_enable), .general_alarm(general_alarm),
        .alarm_icon(alarm_icon), .pct_icon(pct_icon), .num_icon(num_icon), .circle_icon(circle_icon),
        .disp_dashes(disp_dashes), .disp_value(disp_value), .graph_freq_sel(graph_freq_sel),
        .ext_amp_enable(ext_amp_enable));

    pac_mach_model #(.MS_CYC(MSC)) mach_u (.sys_clk(sys_clk), .ext_start(ext_start),
        .ext_alarm_clear(ext_alarm_clear), .overload(overload));

    // verdict and end of run
    task wrap_up();
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // single comparison point
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    // one press-and-release of the given keys
    task press(input logic [3:0] m);
        @(negedge sys_clk);
        keys = m;
        wait_cyc(4);
        keys = 4'h0;
        wait_cyc(4);
    endtask : press

    task t_reset();
        chk({9'h0, pct_icon}, ON);
        chk(disp_value, AMP_DEF);
        chk({7'h0, us_enable, num_icon, circle_icon}, OFF);
        chk({8'h0, general_alarm, alarm_icon}, OFF);
        chk({8'h0, graph_freq_sel, ext_amp_enable}, OFF);
    endtask : t_reset

    task t_start();
        mach_u.set_start(1'b1);
        wait_cyc(6);
        chk({9'h0, us_enable}, ON);
        wait_cyc(3 * MSC);
        chk({9'h0, us_enable}, ON);
        mach_u.set_start(1'b0);
        wait_cyc(6);
        chk({9'h0, us_enable}, OFF);
    endtask : t_start

    task t_amp_step();
        press(K_DN);
        chk(disp_value, AMP_DEF - STEP_SMALL);
        press(K_UP);
        press(K_UP);
        chk(disp_value, AMP_MAX);
    endtask : t_amp_step

    // long hold of down: one-percent repeats, then five-percent repeats
    task t_amp_hold();
        @(negedge sys_clk);
        keys = K_DN;
        wait_cyc(125 * MSC);
        chk(disp_value, 10'h063);
        wait_cyc(1000 * MSC);
        chk(disp_value, 10'h05F);
        wait_cyc(2750 * MSC);
        chk(disp_value, 10'h054);
        wait_cyc(500 * MSC);
        v = disp_value;
        chk({9'h0, (v === 10'h04A || v === 10'h04E)}, ON);
        wait_cyc(250 * MSC);
        chk(disp_value, v - STEP_BIG);
        keys = 4'h0;
        wait_cyc(4);
        press(K_DN);
        amp_exp = v - STEP_BIG - STEP_SMALL;
        chk(disp_value, amp_exp);
    endtask : t_amp_hold

    // register menu walk enabling then disabling external amplitude
    task t_menu_ext();
        press(K_MENU);
        chk({9'h0, num_icon}, ON);
        chk(disp_value, REG_FW);
        repeat (4) press(K_UP);
        chk(disp_value, REG_EXTAMP);
        press(K_MENU);
        chk({9'h0, circle_icon}, ON);
        chk(disp_value, OFF);
        press(K_UP);
        press(K_UP);
        chk(disp_value, ON);
        press(K_MENU);
        chk({8'h0, pct_icon, ext_amp_enable}, 10'h003);
        chk({9'h0, disp_dashes}, ON);
        press(K_UP);
        press(K_MENU);
        chk(disp_value, REG_EXTAMP);
        press(K_MENU);
        press(K_RST);
        chk(disp_value, OFF);
        press(K_MENU);
        chk({8'h0, ext_amp_enable, disp_dashes}, OFF);
        chk(disp_value, amp_exp);
    endtask : t_menu_ext

    task t_nonlatch();
        mach_u.set_start(1'b1);
        wait_cyc(6);
        mach_u.pulse_overload();
        chk({8'h0, general_alarm, alarm_icon}, 10'h003);
        chk({9'h0, us_enable}, OFF);
        mach_u.restart();
        wait_cyc(19 * MSC);
        chk({9'h0, us_enable}, OFF);
        wait_cyc(4 * MSC);
        chk({8'h0, us_enable, general_alarm}, 10'h002);
        mach_u.set_start(1'b0);
    endtask : t_nonlatch

    // graph select on 102, latching alarms on 103
    task t_cfg();
        press(K_MENU);
        press(K_DN);
        press(K_DN);
        chk(disp_value, REG_GRAPH);
        press(K_MENU);
        press(K_UP);
        press(K_MENU);
        chk({9'h0, graph_freq_sel}, ON);
        press(K_MENU);
        press(K_UP);
        press(K_MENU);
        chk(disp_value, OFF);
        press(K_UP);
        press(K_MENU);
    endtask : t_cfg

    task t_latch();
        mach_u.set_start(1'b1);
        wait_cyc(6);
        mach_u.pulse_overload();
        mach_u.restart();
        wait_cyc(30 * MSC);
        chk({8'h0, general_alarm, us_enable}, 10'h002);
        press(K_RST);
        chk({9'h0, general_alarm}, OFF);
        wait_cyc(23 * MSC);
        chk({9'h0, us_enable}, ON);
        mach_u.pulse_overload();
        chk({9'h0, alarm_icon}, ON);
        mach_u.pulse_clear();
        chk({9'h0, general_alarm}, OFF);
        mach_u.set_start(1'b0);
    endtask : t_latch

    // main sequence
    initial
    begin
        amp_exp = AMP_DEF;
        wait_cyc(2);
        rst_n = 1'b1;
        wait_cyc(3);
        t_reset();
        t_start();
        t_amp_step();
        t_amp_hold();
        t_menu_ext();
        t_nonlatch();
        t_cfg();
        t_latch();
        wrap_up();
    end

    // watchdog against a hang
    initial
    begin
        #400000;
        num_errors++;
        wrap_up();
    end
endmodule : tb_pac_ctrl
